// *** hw/miex_pkg.sv ***
`default_nettype none
package miex_pkg;
    // Bus and data widths
    localparam int          WB_AW           = 12;
    localparam int          DATA_W          = 8;
    localparam int          PC_W            = 13;
    localparam int          FILE_AW         = 7;
    localparam int          FILE_DEPTH      = 128;
    localparam int          STACK_DEPTH     = 8;
    localparam int          PRESC_W         = 8;

    // Register byte offsets
    localparam logic [11:0] OFS_ACC         = 12'h000;
    localparam logic [11:0] OFS_STATUS      = 12'h004;
    localparam logic [11:0] OFS_PC          = 12'h008;
    localparam logic [11:0] OFS_WDT         = 12'h00c;
    localparam logic [11:0] OFS_PRESC       = 12'h010;
    localparam logic [11:0] OFS_INSTR       = 12'h014;
    localparam logic [11:0] OFS_STACK       = 12'h018;
    localparam logic [11:0] OFS_CTRL        = 12'h01c;
    localparam logic [11:0] OFS_FILE_BASE   = 12'h200;
    localparam logic [11:0] OFS_FILE_MASK   = 12'he03;

    // Status bit positions
    localparam int          ST_CARRY        = 0;
    localparam int          ST_HALF_CARRY   = 1;
    localparam int          ST_ZERO         = 2;
    localparam int          ST_PWRDN_N      = 3;
    localparam int          ST_EXP_N        = 4;

    // Instruction word fields
    localparam int          INS_OP_LSB      = 8;
    localparam int          INS_OP_MSB      = 10;
    localparam int          INS_DEST        = 12;

    // Control register bits
    localparam int          CTL_WAKE        = 0;
    localparam int          CTL_WDT_CLR     = 1;
    localparam int          CTL_SLEEP       = 0;
    localparam int          CTL_BUSY        = 1;

    // Reset values
    localparam logic [7:0]  ACC_RST         = 8'h00;
    localparam logic [4:0]  STATUS_RST      = 5'h18;
    localparam logic [7:0]  WDT_CLEAR_VAL   = 8'h00;

    // Operation codes of the instruction register
    typedef enum logic [2:0] {
        MIEX_OP_NOP     = 3'h0,
        MIEX_OP_RET_LIT = 3'h1,
        MIEX_OP_RETURN  = 3'h2,
        MIEX_OP_ROT     = 3'h3,
        MIEX_OP_SLEEP   = 3'h4,
        MIEX_OP_SUBL    = 3'h5,
        MIEX_OP_XORL    = 3'h6
    } miex_op_t;

    // Execution sequencer
    typedef enum logic {
        MIEX_IDLE,
        MIEX_SECOND
    } miex_state_t;
endpackage
`default_nettype wire

// *** hw/miex_alu_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operands into and results out of the arithmetic unit
interface miex_alu_if;
    import miex_pkg::*;
    miex_op_t    op;        // Operation to evaluate
    logic [7:0]  literal;   // Immediate operand
    logic [7:0]  acc;       // Current accumulator
    logic [7:0]  fdata;     // Addressed file register
    logic        carry_in;  // Current carry flag
    logic [7:0]  result;    // Computed value
    logic        carry;     // Carry out
    logic        half;      // Half-carry out
    logic        zero;      // Result is zero

    modport core (output op, literal, acc, fdata, carry_in, input result, carry, half, zero);
    modport alu  (input op, literal, acc, fdata, carry_in, output result, carry, half, zero);
endinterface
`default_nettype wire

// *** hw/miex_alu.sv ***
`timescale 1ns/10ps
`default_nettype none
module miex_alu
    import miex_pkg::*;
(
    miex_alu_if.alu alu
);
    logic [8:0] sum;     // Full subtraction with carry out
    logic [4:0] nib;     // Low nibble subtraction

    // Combinational evaluation of every operation
    always_comb
    begin
        sum        = {1'b0, alu.literal} + {1'b0, ~alu.acc} + 9'h001;
        nib        = {1'b0, alu.literal[3:0]} + {1'b0, ~alu.acc[3:0]} + 5'h01;
        alu.result = alu.acc;
        alu.carry  = alu.carry_in;
        alu.half   = 1'b0;
        case (alu.op)
            MIEX_OP_RET_LIT:
                alu.result = alu.literal;
            MIEX_OP_ROT:
            begin
                alu.result = {alu.carry_in, alu.fdata[7:1]};
                alu.carry  = alu.fdata[0];
            end
            MIEX_OP_SUBL:
            begin
                alu.result = sum[7:0];
                alu.carry  = sum[8];
                alu.half   = nib[4];
            end
            MIEX_OP_XORL:
                alu.result = alu.acc ^ alu.literal;
            default:
                alu.result = alu.acc;
        endcase
        alu.zero = (alu.result == 8'h00);
    end
endmodule
`default_nettype wire

// *** hw/miex_core.sv ***
`timescale 1ns/10ps
`default_nettype none
module miex_core
    import miex_pkg::*;
#(
    parameter int STACK_N = STACK_DEPTH,   // Return stack entries, power of two
    parameter int PRE_W   = PRESC_W        // Watchdog prescaler width
)
(
    input  wire logic        clk_i,        // Instruction-cycle clock
    input  wire logic        rst_i,        // Synchronous reset, active high
    input  wire logic        wb_cyc_i,     // Wishbone cycle
    input  wire logic        wb_stb_i,     // Wishbone strobe
    input  wire logic        wb_we_i,      // Wishbone write enable
    input  wire logic [11:0] wb_adr_i,     // Byte address
    input  wire logic [3:0]  wb_sel_i,     // Byte lanes
    input  wire logic [31:0] wb_dat_i,     // Write data
    output logic      [31:0] wb_dat_o,     // Read data
    output logic             wb_ack_o,     // Acknowledge
    output logic             stack_pop_o,  // One-cycle pop of return stack
    output logic             wdt_clear_o,  // One-cycle watchdog clear
    output logic             osc_stop_o,   // Oscillator stop request
    output logic             busy_o        // Second cycle of a return
);
    localparam int SP_W = $clog2(STACK_N);

    // Bus slave state
    logic             ack_q, ack_d;
    logic [31:0]      rdat_q, rdat_d;
    // Architectural state
    logic [7:0]       acc_q, acc_d;              // Accumulator
    logic [4:0]       status_q, status_d;        // Status flags
    logic [PC_W-1:0]  pc_q, pc_d;                // Program counter
    logic [7:0]       file_q [FILE_DEPTH];       // Register file
    logic [7:0]       file_d [FILE_DEPTH];
    logic [PC_W-1:0]  stack_q [STACK_N];         // Return stack
    logic [PC_W-1:0]  stack_d [STACK_N];
    logic [SP_W-1:0]  sp_q, sp_d;                // Next free slot
    logic [7:0]       wdt_q, wdt_d;              // Watchdog counter
    logic [PRE_W-1:0] pre_q, pre_d;              // Watchdog prescaler
    logic             sleep_q, sleep_d;          // Sleep state
    miex_state_t      state_q, state_d;          // Sequencer
    logic             pop_q, pop_d;              // Pop pulse
    logic             wclr_q, wclr_d;            // Watchdog clear pulse

    // Decoded bus strobes
    logic             req;
    logic             wr_commit;
    logic             file_hit;
    logic [FILE_AW-1:0] file_idx;
    logic             ins_go;
    logic [SP_W-1:0]  sp_top;
    logic [7:0]       ins_k;
    logic             ins_dest;

    miex_alu_if alu_bus ();

    miex_alu u_alu
    (
        .alu (alu_bus.alu)
    );

    assign req       = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master samples ack
    assign wr_commit = req & wb_we_i & ack_q & wb_sel_i[0];
    assign file_hit  = (wb_adr_i & OFS_FILE_MASK) == OFS_FILE_BASE;
    assign file_idx  = wb_adr_i[FILE_AW+1:2];
    assign sp_top    = sp_q - 1'b1;
    assign ins_k     = wb_dat_i[7:0];
    assign ins_dest  = wb_dat_i[INS_DEST];
    // Instructions are refused while asleep or in a return's second cycle
    assign ins_go    = wr_commit & (wb_adr_i == OFS_INSTR) & ~sleep_q & (state_q == MIEX_IDLE);

    // Feed the arithmetic unit straight from the instruction write
    always_comb
    begin
        alu_bus.op       = miex_op_t'(wb_dat_i[INS_OP_MSB:INS_OP_LSB]);
        alu_bus.literal  = ins_k;
        alu_bus.acc      = acc_q;
        alu_bus.fdata    = file_q[ins_k[FILE_AW-1:0]];
        alu_bus.carry_in = status_q[ST_CARRY];
    end

    // Bus answer: ack one cycle after the request, dropped after one cycle
    always_comb
    begin
        ack_d  = req & ~ack_q;
        rdat_d = rdat_q;
        if (req & ~ack_q)
        begin
            rdat_d = 32'h0000_0000;
            if (file_hit)
                rdat_d[7:0] = file_q[file_idx];
            else
            begin
                case (wb_adr_i)
                    OFS_ACC:    rdat_d[7:0] = acc_q;
                    OFS_STATUS: rdat_d[4:0] = status_q;
                    OFS_PC:     rdat_d[PC_W-1:0] = pc_q;
                    OFS_WDT:    rdat_d[7:0] = wdt_q;
                    OFS_PRESC:  rdat_d[PRE_W-1:0] = pre_q;
                    OFS_STACK:  rdat_d[PC_W-1:0] = stack_q[sp_top];
                    OFS_CTRL:
                    begin
                        rdat_d[CTL_SLEEP] = sleep_q;
                        rdat_d[CTL_BUSY]  = (state_q != MIEX_IDLE);
                    end
                    // Unmapped offsets read as zero
                    default:    rdat_d = 32'h0000_0000;
                endcase
            end
        end
    end

    // Execution, watchdog and software writes
    always_comb
    begin
        acc_d    = acc_q;
        status_d = status_q;
        pc_d     = pc_q;
        file_d   = file_q;
        stack_d  = stack_q;
        sp_d     = sp_q;
        wdt_d    = wdt_q;
        pre_d    = pre_q + 1'b1;
        sleep_d  = sleep_q;
        state_d  = MIEX_IDLE;
        pop_d    = 1'b0;
        wclr_d   = 1'b0;

        // Watchdog runs from the prescaler, also during sleep
        if (pre_q == {PRE_W{1'b1}})
        begin
            wdt_d = wdt_q + 8'h01;
            // Overflow flags a time-out and ends sleep
            if (wdt_q == 8'hff)
            begin
                status_d[ST_EXP_N] = 1'b0;
                sleep_d            = 1'b0;
            end
        end

        // Software writes of state registers
        if (wr_commit)
        begin
            if (file_hit)
                file_d[file_idx] = wb_dat_i[7:0];
            else
            begin
                case (wb_adr_i)
                    OFS_ACC:    acc_d = wb_dat_i[7:0];
                    // Only carry, half-carry and zero are writable
                    OFS_STATUS: status_d[ST_ZERO:ST_CARRY] = wb_dat_i[ST_ZERO:ST_CARRY];
                    OFS_PC:     pc_d = wb_dat_i[PC_W-1:0];
                    OFS_STACK:
                    begin
                        // A push wraps round like the hardware stack
                        stack_d[sp_q] = wb_dat_i[PC_W-1:0];
                        sp_d          = sp_q + 1'b1;
                    end
                    OFS_CTRL:
                    begin
                        if (wb_dat_i[CTL_WAKE])
                            sleep_d = 1'b0;
                        if (wb_dat_i[CTL_WDT_CLR])
                        begin
                            wdt_d  = WDT_CLEAR_VAL;
                            pre_d  = '0;
                            wclr_d = 1'b1;
                        end
                    end
                    default:    acc_d = acc_q;
                endcase
            end
        end

        // Instruction issue
        if (ins_go)
        begin
            pc_d = pc_q + 1'b1;
            case (alu_bus.op)
                MIEX_OP_RET_LIT:
                begin
                    acc_d   = alu_bus.result;
                    pc_d    = stack_q[sp_top];
                    sp_d    = sp_top;
                    pop_d   = 1'b1;
                    state_d = MIEX_SECOND;
                end
                MIEX_OP_RETURN:
                begin
                    pc_d    = stack_q[sp_top];
                    sp_d    = sp_top;
                    pop_d   = 1'b1;
                    state_d = MIEX_SECOND;
                end
                MIEX_OP_ROT:
                begin
                    if (ins_dest)
                        file_d[ins_k[FILE_AW-1:0]] = alu_bus.result;
                    else
                        acc_d = alu_bus.result;
                    status_d[ST_CARRY] = alu_bus.carry;
                end
                MIEX_OP_SLEEP:
                begin
                    wdt_d  = WDT_CLEAR_VAL;
                    pre_d  = '0;
                    wclr_d = 1'b1;
                    status_d[ST_PWRDN_N] = 1'b0;
                    status_d[ST_EXP_N] = 1'b1;
                    sleep_d = 1'b1;
                end
                MIEX_OP_SUBL:
                begin
                    acc_d                   = alu_bus.result;
                    status_d[ST_CARRY]      = alu_bus.carry;
                    status_d[ST_HALF_CARRY] = alu_bus.half;
                    status_d[ST_ZERO]       = alu_bus.zero;
                end
                MIEX_OP_XORL:
                begin
                    acc_d             = alu_bus.result;
                    status_d[ST_ZERO] = alu_bus.zero;
                end
                default:
                    acc_d = acc_q;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
            acc_q    <= ACC_RST;
            status_q <= STATUS_RST;
            pc_q     <= '0;
            sp_q     <= '0;
            wdt_q    <= WDT_CLEAR_VAL;
            pre_q    <= '0;
            sleep_q  <= 1'b0;
            state_q  <= MIEX_IDLE;
            pop_q    <= 1'b0;
            wclr_q   <= 1'b0;
            for (int i = 0; i < FILE_DEPTH; i++)
                file_q[i] <= 8'h00;
            for (int j = 0; j < STACK_N; j++)
                stack_q[j] <= '0;
        end
        else
        begin
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
            acc_q    <= acc_d;
            status_q <= status_d;
            pc_q     <= pc_d;
            sp_q     <= sp_d;
            wdt_q    <= wdt_d;
            pre_q    <= pre_d;
            sleep_q  <= sleep_d;
            state_q  <= state_d;
            pop_q    <= pop_d;
            wclr_q   <= wclr_d;
            file_q   <= file_d;
            stack_q  <= stack_d;
        end
    end

    // Outputs come straight from flip-flops
    assign wb_ack_o    = ack_q;
    assign wb_dat_o    = rdat_q;
    assign stack_pop_o = pop_q;
    assign wdt_clear_o = wclr_q;
    assign osc_stop_o  = sleep_q;
    assign busy_o      = (state_q == MIEX_SECOND);
endmodule
`default_nettype wire

// *** sim/miex_core_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level checker for return, power-down and bus timing
module miex_core_monitor
    import miex_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        stack_pop_o,
    input wire logic        wdt_clear_o,
    input wire logic        osc_stop_o,
    input wire logic        busy_o
);
    logic       ins_ok; // Instruction write the core must execute
    logic       ret_ok; // Either kind of return accepted
    logic       slp_ok; // Power-down accepted
    logic [2:0] op;     // Operation field of the written word
    assign op     = wb_dat_i[10:8];
    // Writes while asleep or busy are refused, so they are left out
    assign ins_ok = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_INSTR && !busy_o && !osc_stop_o;
    assign ret_ok = ins_ok && (op == 3'h1 || op == 3'h2);
    assign slp_ok = ins_ok && op == 3'h4;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ret_pop_a: assert property (ret_ok |=> stack_pop_o)
        else $error("return did not pop the stack");
    ret_two_a: assert property (ret_ok |=> busy_o ##1 !busy_o)
        else $error("return did not take two cycles");
    pop_cause_a: assert property (stack_pop_o |-> $past(ret_ok))
        else $error("stack popped without a return");
    busy_cause_a: assert property (busy_o |-> $past(ret_ok))
        else $error("busy without a return");
    plain_one_a: assert property (ins_ok && !ret_ok |=> !busy_o && !stack_pop_o)
        else $error("ordinary instruction took a second cycle");
    slp_wdt_a: assert property (slp_ok |=> wdt_clear_o ##1 !wdt_clear_o)
        else $error("power-down did not clear the watchdog once");
    slp_osc_a: assert property (slp_ok |=> osc_stop_o)
        else $error("power-down did not stop the oscillator");
    osc_cause_a: assert property ($rose(osc_stop_o) |-> $past(slp_ok))
        else $error("oscillator stopped without power-down");
    ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not a single pulse after request");
    ret_c: cover property (ret_ok);
    slp_c: cover property (slp_ok);
    rot_c: cover property (ins_ok && op == 3'h3 && wb_dat_i[12]);
endmodule
bind miex_core miex_core_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .stack_pop_o(stack_pop_o), .wdt_clear_o(wdt_clear_o), .osc_stop_o(osc_stop_o),
    .busy_o(busy_o));
`default_nettype wire

// *** sim/miex_core_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module miex_core_tb;
    import miex_pkg::*;
    logic        clk_i;
    logic        rst_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        stack_pop_o;
    logic        wdt_clear_o;
    logic        osc_stop_o;
    logic        busy_o;
    int          n_fail;   // Mismatches seen
    int          compares; // Comparisons made
    logic [31:0] rd;       // Word taken at the acknowledge
    logic [3:0]  fl;       // Pop, busy, watchdog clear, oscillator stop
    logic [3:0]  sel_v;    // Byte lanes of the next access
    // Short prescaler keeps watchdog counts quick
    miex_core #(.STACK_N(8), .PRE_W(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stack_pop_o(stack_pop_o), .wdt_clear_o(wdt_clear_o),
        .osc_stop_o(osc_stop_o), .busy_o(busy_o));
    // 25 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One classic cycle, held until ack is sampled high at a rising edge
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= sel_v;
        wb_dat_i <= d;
        // Read just after the edge, outputs still hold what that edge sampled
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input string nm, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    // Side-effect pulses are caught in the cycle after the commit edge
    task automatic wr_cap(input logic [11:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        @(negedge clk_i);
        fl = {stack_pop_o, busy_o, wdt_clear_o, osc_stop_o};
    endtask
    task automatic exec(input logic dest, input miex_op_t op, input logic [7:0] k);
        wr_cap(OFS_INSTR, {19'h0, dest, 1'b0, op, k});
    endtask
    task automatic t_reset;
        rdc(OFS_STATUS, "status", 32'h18);
        rdc(OFS_ACC, "acc", 32'h0);
        wb(1'b1, 12'h100, 32'hff);
        rdc(12'h100, "unmapped", 32'h0);
        // Low lane off, so the write must be ignored
        sel_v = 4'he;
        wb(1'b1, OFS_ACC, 32'h55);
        sel_v = 4'hf;
        rdc(OFS_ACC, "acc lane off", 32'h0);
        $display("reset test done");
    endtask
    task automatic t_xor;
        wb(1'b1, OFS_ACC, 32'ha5);
        wb(1'b1, OFS_STATUS, 32'h03);
        exec(1'b0, MIEX_OP_XORL, 8'ha5);
        chk("xor pulses", 32'h0, {28'h0, fl});
        rdc(OFS_ACC, "xor acc", 32'h0);
        rdc(OFS_STATUS, "xor status", 32'h1f);
        exec(1'b0, MIEX_OP_XORL, 8'h0f);
        rdc(OFS_ACC, "xor acc", 32'h0f);
        rdc(OFS_STATUS, "xor status", 32'h1b);
        $display("xor test done");
    endtask
    // Equal, borrow, nibble borrow, extremes
    task automatic t_sub;
        logic [7:0] kv [5] = '{8'h05, 8'h02, 8'h10, 8'hff, 8'h00};
        logic [7:0] av [5] = '{8'h05, 8'h03, 8'h01, 8'h00, 8'hff};
        logic [7:0] r;
        for (int i = 0; i < 5; i++)
        begin
            r = kv[i] - av[i];
            wb(1'b1, OFS_ACC, {24'h0, av[i]});
            exec(1'b0, MIEX_OP_SUBL, kv[i]);
            rdc(OFS_ACC, "sub acc", {24'h0, r});
            rdc(OFS_STATUS, "sub flags", {29'h3, r == 8'h0, kv[i][3:0] >= av[i][3:0], kv[i] >= av[i]});
        end
        $display("subtract test done");
    endtask
    // Top file address, both destinations, zero flag must survive
    task automatic t_rot;
        wb(1'b1, 12'h3fc, 32'h81);
        wb(1'b1, OFS_STATUS, 32'h04);
        exec(1'b1, MIEX_OP_ROT, 8'h7f);
        rdc(12'h3fc, "rot file", 32'h40);
        rdc(OFS_STATUS, "rot carry", 32'h1d);
        exec(1'b0, MIEX_OP_ROT, 8'h7f);
        rdc(OFS_ACC, "rot acc", 32'ha0);
        rdc(12'h3fc, "rot file kept", 32'h40);
        rdc(OFS_STATUS, "rot carry", 32'h1c);
        $display("rotate test done");
    endtask
    task automatic t_ret;
        wb(1'b1, OFS_STACK, 32'h123);
        wb(1'b1, OFS_STACK, 32'h456);
        wb(1'b1, OFS_STATUS, 32'h07);
        exec(1'b0, MIEX_OP_RET_LIT, 8'h3c);
        chk("retlit pulses", 32'hc, {28'h0, fl});
        rdc(OFS_ACC, "retlit acc", 32'h3c);
        rdc(OFS_PC, "retlit pc", 32'h456);
        rdc(OFS_STATUS, "retlit status", 32'h1f);
        exec(1'b0, MIEX_OP_RETURN, 8'h00);
        chk("return pulses", 32'hc, {28'h0, fl});
        rdc(OFS_PC, "return pc", 32'h123);
        rdc(OFS_STACK, "stack top", 32'h0);
        rdc(OFS_STATUS, "return status", 32'h1f);
        $display("return test done");
    endtask
    // Watchdog runs a while first so the clear is a real change
    task automatic t_sleep;
        wr_cap(OFS_CTRL, 32'h2);
        chk("ctrl clear", 32'h2, {28'h0, fl});
        repeat (12) @(posedge clk_i);
        exec(1'b0, MIEX_OP_SLEEP, 8'h00);
        chk("sleep pulses", 32'h3, {28'h0, fl});
        rdc(OFS_WDT, "wdt", 32'h0);
        rdc(OFS_STATUS, "sleep status", 32'h17);
        rdc(OFS_CTRL, "asleep", 32'h1);
        exec(1'b0, MIEX_OP_XORL, 8'hff);
        rdc(OFS_ACC, "acc while asleep", 32'h3c);
        wb(1'b1, OFS_CTRL, 32'h1);
        rdc(OFS_CTRL, "awake", 32'h0);
        $display("sleep test done");
    endtask
    task automatic test_done;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        n_fail = 0;
        compares = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h0;
        wb_sel_i = 4'h0;
        sel_v = 4'hf;
        wb_dat_i = 32'h0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_xor;
        t_sub;
        t_rot;
        t_ret;
        t_sleep;
        test_done;
    end
    // Tests need well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_fail++;
        test_done;
    end
endmodule
`default_nettype wire
